// File: bench/bac_burst_counter_assertions.sv
`timescale 1ns/1ps
module bac_burst_counter_checker
  import bac_pkg::*;
#(
  parameter int ADDR_W = BAC_ADDR_W // Address width
)
(
  input wire logic clk, // Port clock
  input wire logic rst_n, // Synchronous reset
  input wire logic master_reset_n, // Asynchronous reset
  input wire logic counter_or_mask_select, // Counter or mask side
  input wire logic counter_clear_n, // Clear
  input wire logic address_strobe_n, // Strobe
  input wire logic count_enable_n, // Count enable
  input wire logic port_select_low, // Chip select low
  input wire logic port_select_high, // Chip select high
  input wire logic [ADDR_W-1:0] addr_in, // Address pins in
  input wire logic [ADDR_W-1:0] addr_out, // Readback value
  input wire logic addr_oe, // Readback drive
  input wire logic [ADDR_W-1:0] ram_addr, // Counter value
  input wire logic wrap_flag_n, // Wrap flag
  input wire logic data_hiz, // Data float
  input wire bac_op_t last_op, // Last operation
  input wire logic mask_ok // Mask form
);
  // Decoded requests
  wire logic rd = counter_clear_n && !address_strobe_n && count_enable_n;
  wire logic crd = rd && counter_or_mask_select;
  wire logic ld = counter_or_mask_select && counter_clear_n && !address_strobe_n && !count_enable_n;
  wire logic hold = counter_or_mask_select && counter_clear_n && address_strobe_n && count_enable_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !master_reset_n);
  a_load_counter: assert property (ld |=> ram_addr == $past(addr_in) && wrap_flag_n)
    else $error("counter load wrong");
  a_hold_all: assert property (hold |=> $stable(ram_addr) && $stable(wrap_flag_n))
    else $error("hold changed state");
  a_mask_side_keep: assert property (!counter_or_mask_select |=> $stable(ram_addr))
    else $error("mask op moved counter");
  a_readback_drive: assert property (rd |=> addr_oe)
    else $error("readback not driven");
  a_no_readback: assert property (!rd |=> !addr_oe)
    else $error("address driven without readback");
  a_counter_readback: assert property (crd |=> addr_out == $past(ram_addr))
    else $error("counter readback value wrong");
  a_hiz_selected: assert property (rd && !port_select_low && port_select_high |=> data_hiz)
    else $error("data not floated");
  a_clear_op: assert property (counter_or_mask_select && !counter_clear_n
    |=> last_op == BAC_OP_CNT_CLEAR && wrap_flag_n)
    else $error("counter clear not taken");
  a_mask_clear: assert property (!counter_or_mask_select && !counter_clear_n
    |=> wrap_flag_n ##1 mask_ok)
    else $error("mask clear wrong");
  a_mreset_async: assert property (disable iff (!rst_n)
    !master_reset_n |-> ram_addr == '0 && wrap_flag_n)
    else $error("master reset not applied");
endmodule
bind bac_burst_counter bac_burst_counter_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
  .rst_n(rst_n), .master_reset_n(master_reset_n), .counter_or_mask_select(counter_or_mask_select),
  .counter_clear_n(counter_clear_n), .address_strobe_n(address_strobe_n),
  .count_enable_n(count_enable_n), .port_select_low(port_select_low),
  .port_select_high(port_select_high), .addr_in(addr_in), .addr_out(addr_out),
  .addr_oe(addr_oe), .ram_addr(ram_addr), .wrap_flag_n(wrap_flag_n), .data_hiz(data_hiz),
  .last_op(last_op), .mask_ok(mask_ok));

// File: bench/bac_host_model.sv
`timescale 1ns/1ps
module bac_host_model
  import bac_pkg::*;
#(
  parameter int ADDR_W = BAC_ADDR_W // Address width
)
(
  input wire bac_op_t op, // Operation to present
  input wire logic [ADDR_W-1:0] val, // Address for loads
  output bac_ctrl_t ctrl, // Control pins
  output logic [ADDR_W-1:0] addr_in // Address pins
);
  // Pin pattern per operation; the reserved pattern is never issued
  always_comb
  begin
    case (op)
      BAC_OP_CNT_CLEAR: ctrl = 4'hB;
      BAC_OP_CNT_LOAD: ctrl = 4'hC;
      BAC_OP_CNT_READ: ctrl = 4'hD;
      BAC_OP_CNT_INC: ctrl = 4'hE;
      BAC_OP_MSK_CLEAR: ctrl = 4'h3;
      BAC_OP_MSK_LOAD: ctrl = 4'h4;
      BAC_OP_MSK_READ: ctrl = 4'h5;
      default: ctrl = 4'hF;
    endcase
  end
  // Address pins carry data only on loads, the inverted value of val otherwise
  assign addr_in = (op == BAC_OP_CNT_LOAD || op == BAC_OP_MSK_LOAD) ? val : ~val;
endmodule

// File: bench/burst_address_counter_mask_test.sv
`timescale 1ns/1ps
module burst_address_counter_mask_test;
  import bac_pkg::*;
  logic clk = 0, rst_n = 0, master_reset_n_n = 0, oe, hiz, wrap, mok;
  bac_op_t op = BAC_OP_HOLD, lop;
  bac_ctrl_t ctrl;
  bac_sel_t sel = 2'b10, sel_nxt = 2'b10;
  logic [17:0] val = '0, ain, aout, ram;
  int error_cnt = 0, total_checks = 0;
  // Clock and far-side model
  always #5 clk = ~clk;
  bac_host_model u_bac_host_model (.op(op), .val(val), .ctrl(ctrl), .addr_in(ain));
  bac_burst_counter u_bac_burst_counter (.clk(clk), .rst_n(rst_n), .master_reset_n(master_reset_n_n),
    .counter_or_mask_select(ctrl.counter_or_mask_select), .counter_clear_n(ctrl.counter_clear_n),
    .address_strobe_n(ctrl.address_strobe_n), .count_enable_n(ctrl.count_enable_n),
    .port_select_low(sel.port_select_low), .port_select_high(sel.port_select_high),
    .addr_in(ain), .addr_out(aout), .addr_oe(oe), .ram_addr(ram), .wrap_flag_n(wrap),
    .data_hiz(hiz), .last_op(lop), .mask_ok(mok));
  // One operation taken at one edge
  task automatic do_op(input bac_op_t o, input logic [17:0] v);
    @(negedge clk);
    op = o;
    val = v;
    sel = sel_nxt;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    chk("counter", 18'h0, ram);
    chk("wrap", 18'h1, wrap);
    do_op(BAC_OP_MSK_READ, 18'h0);
    chk("mask", 18'h3FFFF, aout);
    chk("oe", 18'h1, oe);
    $display("reset test done");
  endtask
  task automatic t_wrap;
    do_op(BAC_OP_MSK_LOAD, 18'h3F);
    do_op(BAC_OP_CNT_LOAD, 18'h8);
    chk("counter", 18'h8, ram);
    for (int i = 9; i <= 'h3F; i++)
    begin
      do_op(BAC_OP_CNT_INC, 18'h0);
      chk("counter", 18'(i), ram);
      chk("wrap", {17'h0, i != 'h3F}, wrap);
    end
    do_op(BAC_OP_CNT_INC, 18'h0);
    chk("counter", 18'h8, ram);
    chk("wrap", 18'h1, wrap);
    repeat (3) do_op(BAC_OP_HOLD, 18'h0);
    chk("counter", 18'h8, ram);
    $display("wrap test done");
  endtask
  task automatic t_step2;
    do_op(BAC_OP_MSK_LOAD, 18'h3E);
    do_op(BAC_OP_CNT_LOAD, 18'h41);
    do_op(BAC_OP_CNT_INC, 18'h0);
    chk("counter", 18'h43, ram);
    do_op(BAC_OP_CNT_CLEAR, 18'h0);
    chk("counter", 18'h41, ram);
    chk("mask_ok", 18'h1, mok);
    chk("last_op", 18'(BAC_OP_CNT_CLEAR), 18'(lop));
    do_op(BAC_OP_MSK_LOAD, 18'h3C);
    do_op(BAC_OP_HOLD, 18'h0);
    chk("mask_ok", 18'h0, mok);
    $display("step test done");
  endtask
  task automatic t_mclear;
    do_op(BAC_OP_MSK_LOAD, 18'h3);
    do_op(BAC_OP_CNT_LOAD, 18'h106);
    do_op(BAC_OP_CNT_CLEAR, 18'h0);
    chk("counter", 18'h104, ram);
    repeat (4) do_op(BAC_OP_CNT_INC, 18'h0);
    chk("counter", 18'h104, ram);
    do_op(BAC_OP_MSK_CLEAR, 18'h0);
    do_op(BAC_OP_CNT_CLEAR, 18'h0);
    chk("counter", 18'h0, ram);
    do_op(BAC_OP_MSK_READ, 18'h0);
    chk("mask", 18'h3FFFF, aout);
    $display("clear test done");
  endtask
  task automatic t_readback;
    do_op(BAC_OP_CNT_LOAD, 18'h2A5);
    sel_nxt = 2'b01;
    do_op(BAC_OP_CNT_READ, 18'h0);
    chk("readback", 18'h2A5, aout);
    chk("hiz", 18'h1, hiz);
    sel_nxt = 2'b10;
    do_op(BAC_OP_MSK_READ, 18'h0);
    chk("hiz", 18'h0, hiz);
    do_op(BAC_OP_CNT_INC, 18'h0);
    chk("counter", 18'h2A6, ram);
    chk("oe", 18'h0, oe);
    $display("readback test done");
  endtask
  task automatic t_async;
    do_op(BAC_OP_MSK_LOAD, 18'h7);
    do_op(BAC_OP_CNT_INC, 18'h0);
    chk("counter", 18'h2A7, ram);
    chk("wrap", 18'h0, wrap);
    @(negedge clk);
    op = BAC_OP_HOLD;
    #2 master_reset_n_n = 0;
    #1 chk("counter", 18'h0, ram);
    chk("wrap", 18'h1, wrap);
    @(negedge clk);
    #2 master_reset_n_n = 1;
    repeat (2) @(negedge clk);
    do_op(BAC_OP_MSK_READ, 18'h0);
    chk("mask", 18'h3FFFF, aout);
    $display("master reset test done");
  endtask
  // Watchdog
  initial
  begin
    #20000;
    error_cnt++;
    test_done();
  end
  initial
  begin
    #23 master_reset_n_n = 1;
    repeat (16) @(negedge clk);
    rst_n = 1;
    t_reset();
    t_wrap();
    t_step2();
    t_mclear();
    t_readback();
    t_async();
    test_done();
  end
endmodule

// File: pkg/bac_pkg.sv
package bac_pkg;

  // Port address width, 15 to 18 bits depending on array depth
  localparam int BAC_ADDR_W = 18;

  // Values after reset
  localparam logic BAC_WRAP_FLAG_RST = 1'b1;
  localparam logic BAC_ADDR_OE_RST = 1'b0;
  localparam logic BAC_DATA_HIZ_RST = 1'b0;
  localparam logic BAC_MASK_OK_RST = 1'b1;

  // Readback pipeline depth in clock edges
  localparam int BAC_READBACK_LAT = 1;

  // Operation selected by the control pins at a clock edge
  typedef enum logic [3:0] {
    BAC_OP_HOLD = 4'h0,
    BAC_OP_CNT_CLEAR = 4'h1,
    BAC_OP_CNT_LOAD = 4'h2,
    BAC_OP_CNT_READ = 4'h3,
    BAC_OP_CNT_INC = 4'h4,
    BAC_OP_MSK_CLEAR = 4'h5,
    BAC_OP_MSK_LOAD = 4'h6,
    BAC_OP_MSK_READ = 4'h7,
    BAC_OP_RESERVED = 4'h8
  } bac_op_t;

  // Synchronous control pins of the port
  typedef struct packed {
    logic counter_or_mask_select;
    logic counter_clear_n;
    logic address_strobe_n;
    logic count_enable_n;
  } bac_ctrl_t;

  // Port chip selects
  typedef struct packed {
    logic port_select_low;
    logic port_select_high;
  } bac_sel_t;

endpackage

// File: rtl/bac_burst_counter.sv
`timescale 1ns/1ps
module bac_burst_counter
  import bac_pkg::*;
#(
  parameter int ADDR_W = BAC_ADDR_W
)
(
  input wire logic clk, // Port clock
  input wire logic rst_n, // Synchronous system reset
  input wire logic master_reset_n, // Asynchronous master reset
  input wire logic counter_or_mask_select, // High counter, low mask
  input wire logic counter_clear_n, // Clear request
  input wire logic address_strobe_n, // Address strobe
  input wire logic count_enable_n, // Count enable
  input wire logic port_select_low, // Chip select, active low
  input wire logic port_select_high, // Chip select, active high
  input wire logic [ADDR_W-1:0] addr_in, // Address pins, input side
  output logic [ADDR_W-1:0] addr_out, // Address pins, readback value
  output logic addr_oe, // Address pins driven
  output logic [ADDR_W-1:0] ram_addr, // Counter value to the array
  output logic wrap_flag_n, // Wrap flag, low at top of range
  output logic data_hiz, // Data pins forced to high impedance
  output bac_op_t last_op, // Operation taken at last edge
  output logic mask_ok // Mask holds a permitted form
);

  // Burst registers
  logic [ADDR_W-1:0] counter;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] mirror;

  // Carriers for the pins
  bac_ctrl_t ctrl;
  bac_sel_t sel;
  bac_op_t op;

  // Increment result
  logic [ADDR_W-1:0] inc_value;
  logic inc_at_top;

  // Readback and mask check helpers
  logic port_selected;
  logic readback;
  logic [ADDR_W-1:0] mask_fill;
  logic [ADDR_W-1:0] mask_fill_p1;
  logic mask_form_ok;

  // Master reset release, held off two edges so no register leaves reset mid-edge
  logic [1:0] master_reset_n_sync;
  logic master_reset_n_sync_n;

  // Release synchroniser; the pin still clears it, and through it everything, at once
  always_ff @(posedge clk or negedge master_reset_n)
  begin
    if (!master_reset_n)
      master_reset_n_sync <= 2'h0;
    else
      master_reset_n_sync <= {master_reset_n_sync[0], 1'h1};
  end

  // Register reset taken from the second stage only
  assign master_reset_n_sync_n = master_reset_n_sync[1];

  // Gather control pins into carriers
  assign ctrl.counter_or_mask_select = counter_or_mask_select;
  assign ctrl.counter_clear_n = counter_clear_n;
  assign ctrl.address_strobe_n = address_strobe_n;
  assign ctrl.count_enable_n = count_enable_n;
  assign sel.port_select_low = port_select_low;
  assign sel.port_select_high = port_select_high;

  // Operation from the control pins alone; chip selects play no part
  bac_op_decode u_decode (
    .ctrl (ctrl),
    .op (op)
  );

  // Next counter value for an increment
  bac_incr #(
    .ADDR_W (ADDR_W)
  ) u_incr (
    .counter (counter),
    .mask (mask),
    .mirror (mirror),
    .next_counter (inc_value),
    .next_at_top (inc_at_top)
  );

  // Counter register, touched only by its own load, increment and clear operations
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      counter <= '0;
    else if (!rst_n)
      counter <= '0;
    else
    begin
      case (op)
        BAC_OP_CNT_LOAD: counter <= addr_in;
        BAC_OP_CNT_INC: counter <= inc_value;
        BAC_OP_CNT_CLEAR: counter <= counter & ~mask;
        default: counter <= counter;
      endcase
    end
  end

  // Mask register; reset and mask clear both unmask every bit
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      mask <= '1;
    else if (!rst_n)
      mask <= '1;
    else
    begin
      case (op)
        BAC_OP_MSK_CLEAR: mask <= '1;
        BAC_OP_MSK_LOAD: mask <= addr_in;
        default: mask <= mask;
      endcase
    end
  end

  // Mirror register keeps the start of the burst for the wrap reload
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      mirror <= '0;
    else if (!rst_n)
      mirror <= '0;
    else
    begin
      case (op)
        BAC_OP_CNT_LOAD: mirror <= addr_in;
        BAC_OP_CNT_CLEAR: mirror <= mirror & ~mask;
        default: mirror <= mirror;
      endcase
    end
  end

  // Wrap flag follows increments and is released by the other writes
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      wrap_flag_n <= BAC_WRAP_FLAG_RST;
    else if (!rst_n)
      wrap_flag_n <= BAC_WRAP_FLAG_RST;
    else
    begin
      case (op)
        BAC_OP_CNT_INC: wrap_flag_n <= ~inc_at_top;
        BAC_OP_CNT_CLEAR,
        BAC_OP_CNT_LOAD,
        BAC_OP_MSK_CLEAR,
        BAC_OP_MSK_LOAD: wrap_flag_n <= BAC_WRAP_FLAG_RST;
        default: wrap_flag_n <= wrap_flag_n;
      endcase
    end
  end

  // Array address mirrors the counter, one flop image of it
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      ram_addr <= '0;
    else if (!rst_n)
      ram_addr <= '0;
    else
    begin
      case (op)
        BAC_OP_CNT_LOAD: ram_addr <= addr_in;
        BAC_OP_CNT_INC: ram_addr <= inc_value;
        BAC_OP_CNT_CLEAR: ram_addr <= counter & ~mask;
        default: ram_addr <= counter;
      endcase
    end
  end

  // Readback is a pipelined stage on the address pins
  assign readback = (op == BAC_OP_CNT_READ) || (op == BAC_OP_MSK_READ);
  assign port_selected = !sel.port_select_low && sel.port_select_high;

  // Readback value registered at the edge that takes the request
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      addr_out <= '0;
    else if (!rst_n)
      addr_out <= '0;
    else if (op == BAC_OP_CNT_READ)
      addr_out <= counter;
    else if (op == BAC_OP_MSK_READ)
      addr_out <= mask;
    else
      addr_out <= addr_out;
  end

  // Address pins driven for the cycle after each readback request
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      addr_oe <= BAC_ADDR_OE_RST;
    else if (!rst_n)
      addr_oe <= BAC_ADDR_OE_RST;
    else
      addr_oe <= readback;
  end

  // Data pins float while a readback meets an enabled port
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      data_hiz <= BAC_DATA_HIZ_RST;
    else if (!rst_n)
      data_hiz <= BAC_DATA_HIZ_RST;
    else
      data_hiz <= readback && port_selected;
  end

  // Operation taken, kept for observation
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      last_op <= BAC_OP_HOLD;
    else if (!rst_n)
      last_op <= BAC_OP_HOLD;
    else
      last_op <= op;
  end

  // Permitted masks are 2^n-1 or 2^n-2 and not zero
  assign mask_fill = mask | {{(ADDR_W-1){1'b0}}, 1'b1};
  assign mask_fill_p1 = mask_fill + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign mask_form_ok = ((mask_fill & mask_fill_p1) == '0) && (mask != '0);

  // Mask form check, one cycle behind the mask itself
  always_ff @(posedge clk or negedge master_reset_n_sync_n)
  begin
    if (!master_reset_n_sync_n)
      mask_ok <= BAC_MASK_OK_RST;
    else if (!rst_n)
      mask_ok <= BAC_MASK_OK_RST;
    else
      mask_ok <= mask_form_ok;
  end

endmodule

// File: rtl/bac_incr.sv
`timescale 1ns/1ps
module bac_incr
#(
  parameter int ADDR_W = 18 // Counter width
)
(
  input wire logic [ADDR_W-1:0] counter, // Present counter value
  input wire logic [ADDR_W-1:0] mask, // Mask, one marks a counting bit
  input wire logic [ADDR_W-1:0] mirror, // Reload value on wrap
  output logic [ADDR_W-1:0] next_counter, // Value after one increment
  output logic next_at_top // Unmasked bits of result all ones
);

  logic [ADDR_W-1:0] filled;
  logic [ADDR_W-1:0] sum;
  logic [ADDR_W-1:0] stepped;
  logic at_top;

  // Masked bits forced to one so the carry crosses them; a masked bit 0 makes a step of two
  assign filled = counter | ~mask;
  assign sum = filled + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign at_top = (counter & mask) == mask;

  // Per bit: counting bits take the sum, masked bits keep the counter
  genvar i;
  generate
    for (i = 0; i < ADDR_W; i++)
    begin : g_bit
      assign stepped[i] = mask[i] ? sum[i] : counter[i];
    end
  endgenerate

  // At the top of the range reload from the mirror instead of counting on
  assign next_counter = at_top ? mirror : stepped;
  assign next_at_top = (next_counter & mask) == mask;

endmodule

// File: rtl/bac_op_decode.sv
`timescale 1ns/1ps
module bac_op_decode
  import bac_pkg::*;
(
  input wire bac_ctrl_t ctrl, // Control pins sampled this cycle
  output bac_op_t op // Decoded operation
);

  // Counter side when select is high, mask side when low
  always_comb
  begin
    op = BAC_OP_HOLD;
    if (ctrl.counter_or_mask_select)
    begin
      if (!ctrl.counter_clear_n)
        op = BAC_OP_CNT_CLEAR;
      else if (!ctrl.address_strobe_n && !ctrl.count_enable_n)
        op = BAC_OP_CNT_LOAD;
      else if (!ctrl.address_strobe_n)
        op = BAC_OP_CNT_READ;
      else if (!ctrl.count_enable_n)
        op = BAC_OP_CNT_INC;
      else
        op = BAC_OP_HOLD;
    end
    else
    begin
      if (!ctrl.counter_clear_n)
        op = BAC_OP_MSK_CLEAR;
      else if (!ctrl.address_strobe_n && !ctrl.count_enable_n)
        op = BAC_OP_MSK_LOAD;
      else if (!ctrl.address_strobe_n)
        op = BAC_OP_MSK_READ;
      else
        op = BAC_OP_RESERVED;
    end
  end

endmodule
